/* core/cftm_pkg.sv */
// constants for the per-channel test-mode block: register map, fields, mode codes
// assumes a 32-bit APB slave with byte addresses
package cftm_pkg;
    localparam int          CFTM_AW        = 12;
    localparam int          CFTM_IDW       = 29;
    localparam logic [11:0] CFTM_OFF_MODE  = 12'h000;
    localparam logic [11:0] CFTM_OFF_BASIC = 12'h004;
    localparam logic [11:0] CFTM_OFF_FID   = 12'h008;
    localparam logic [11:0] CFTM_OFF_FMASK = 12'h00C;
    localparam logic [11:0] CFTM_OFF_STAT  = 12'h010;
    localparam logic [11:0] CFTM_OFF_LID   = 12'h014;
    localparam logic [2:0]  CFTM_M_NORMAL  = 3'h0;
    localparam logic [2:0]  CFTM_M_BASIC   = 3'h1;
    localparam logic [2:0]  CFTM_M_LISTEN  = 3'h2;
    localparam logic [2:0]  CFTM_M_EXTLB   = 3'h3;
    localparam logic [2:0]  CFTM_M_INTLB   = 3'h4;
    localparam logic [2:0]  CFTM_M_RESTR   = 3'h5;
    localparam int          CFTM_B_HOLD    = 0;
    localparam int          CFTM_B_SACK    = 1;
    localparam int          CFTM_S_REFUSED = 3;
    localparam int          CFTM_S_CNT_LO  = 8;
    localparam logic [2:0]  CFTM_MODE_RST  = 3'h0;
    localparam logic [1:0]  CFTM_BASIC_RST = 2'h0;
    localparam logic [28:0] CFTM_FID_RST   = 29'h0;
    localparam logic [28:0] CFTM_FMASK_RST = 29'h0;
endpackage

/* core/cftm_top.sv */
// per-channel test-mode control between a CAN FD protocol engine and the bus pins
// assumes the engine drives eng_tx (1 = recessive) and flags its own ack slot
// Notes on behaviour
// - channel mode selectable: normal, basic, listen-only, external, internal loopback, restricted
// - basic mode enables individual test settings: hold transmit recessive, self acknowledge
// - listen-only: no ack, no error frames on bus, still receives
// - internal loopback: transmitted bits loop back internally, no bus needed
// - internal loopback: channel acknowledges its own frames
// - loopback: own frames stored when acceptance filter matches identifier
// - external loopback: frames driven on bus and received back
// - external loopback: channel acknowledges its own frames
`timescale 1ns/1ns
module cftm_top
    import cftm_pkg::*;
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic [CFTM_AW-1:0]  paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // protocol engine side
    input  wire logic                eng_tx,
    input  wire logic                eng_ack_slot,
    output logic                     eng_rx,
    input  wire logic                host_tx_req,
    output logic                     eng_tx_req,
    input  wire logic                eng_frame_ok,
    input  wire logic                eng_frame_own,
    input  wire logic [CFTM_IDW-1:0] eng_frame_id,
    output logic                     rx_store,
    output logic      [CFTM_IDW-1:0] rx_store_id,
    // bus pins
    input  wire logic                can_rx,
    output logic                     can_tx
);
    logic [2:0]          mode_q;
    logic [1:0]          basic_q;
    logic [CFTM_IDW-1:0] fid_q;
    logic [CFTM_IDW-1:0] fmask_q;
    logic                refused_q;
    logic [7:0]          cnt_q;
    logic                rx_s1_q;
    logic                rx_s2_q;
    logic                rx_s3_q;
    logic                bus_rx_q;
    logic                wr_en;
    logic                rd_hit;
    logic                m_listen;
    logic                m_ext;
    logic                m_int;
    logic                m_basic;
    logic                loop;
    logic                self_ack;
    logic                tx_d;
    logic                rx_d;
    logic                match;
    logic                store_d;
    logic                clr_refused;
    logic [3:0]          quiet_q;

    function automatic logic mapped(input logic [CFTM_AW-1:0] a);
        mapped = (a == CFTM_OFF_MODE) || (a == CFTM_OFF_BASIC) || (a == CFTM_OFF_FID)
              || (a == CFTM_OFF_FMASK) || (a == CFTM_OFF_STAT) || (a == CFTM_OFF_LID);
    endfunction

    // bus handshake: zero wait states
    assign pready      = 1'b1;
    assign wr_en       = psel && penable && pwrite;
    assign rd_hit      = mapped(paddr);
    assign pslverr     = psel && penable && !rd_hit;
    assign clr_refused = wr_en && (paddr == CFTM_OFF_STAT) && pwdata[CFTM_S_REFUSED];

    // mode decode
    assign m_listen = (mode_q == CFTM_M_LISTEN);
    assign m_ext    = (mode_q == CFTM_M_EXTLB);
    assign m_int    = (mode_q == CFTM_M_INTLB);
    assign m_basic  = (mode_q == CFTM_M_BASIC);
    assign loop     = m_ext || m_int;
    assign self_ack = eng_ack_slot && (loop || (m_basic && basic_q[CFTM_B_SACK]));

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q  <= CFTM_MODE_RST;
            basic_q <= CFTM_BASIC_RST;
            fid_q   <= CFTM_FID_RST;
            fmask_q <= CFTM_FMASK_RST;
        end else if (wr_en) begin
            unique case (paddr)
                CFTM_OFF_MODE: begin
                    if (pwdata[2:0] <= CFTM_M_RESTR) begin
                        mode_q <= pwdata[2:0];
                    end
                end
                CFTM_OFF_BASIC: basic_q <= pwdata[1:0];
                CFTM_OFF_FID:   fid_q   <= pwdata[CFTM_IDW-1:0];
                CFTM_OFF_FMASK: fmask_q <= pwdata[CFTM_IDW-1:0];
                default: ;
            endcase
        end
    end

    // read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CFTM_OFF_MODE:  prdata <= {29'h0, mode_q};
                CFTM_OFF_BASIC: prdata <= {30'h0, basic_q};
                CFTM_OFF_FID:   prdata <= {3'h0, fid_q};
                CFTM_OFF_FMASK: prdata <= {3'h0, fmask_q};
                CFTM_OFF_STAT:  prdata <= {16'h0, cnt_q, 4'h0, refused_q, mode_q};
                CFTM_OFF_LID:   prdata <= {3'h0, rx_store_id};
                default:        prdata <= 32'h0;
            endcase
        end
    end

    // transmit requests are blocked while silent
    assign eng_tx_req = host_tx_req && !m_listen;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_q <= 1'b0;
        end else if (host_tx_req && m_listen) begin
            refused_q <= 1'b1;
        end else if (clr_refused) begin
            refused_q <= 1'b0;
        end
    end

    // cycles spent silent, saturating, for the long-hold check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 4'h0;
        end else if (!m_listen) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    // bus receive synchroniser, change taken when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_q  <= 1'b1;
            rx_s2_q  <= 1'b1;
            rx_s3_q  <= 1'b1;
            bus_rx_q <= 1'b1;
        end else begin
            rx_s1_q <= can_rx;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            if (rx_s2_q == rx_s3_q) begin
                bus_rx_q <= rx_s3_q;
            end
        end
    end

    // pin and engine receive routing
    always_comb begin
        tx_d = eng_tx;
        rx_d = bus_rx_q;
        unique case (1'b1)
            m_listen: tx_d = 1'b1;
            m_int: begin
                tx_d = 1'b1;
                rx_d = eng_tx && !self_ack;
            end
            m_ext: rx_d = bus_rx_q && eng_tx && !self_ack;
            m_basic: begin
                tx_d = eng_tx || basic_q[CFTM_B_HOLD];
                rx_d = bus_rx_q && !self_ack;
            end
            default: ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_tx <= 1'b1;
            eng_rx <= 1'b1;
        end else begin
            can_tx <= tx_d;
            eng_rx <= rx_d;
        end
    end

    // acceptance of completed frames, own frames only in loopback
    assign match   = ((eng_frame_id ^ fid_q) & fmask_q) == '0;
    assign store_d = eng_frame_ok && match && (!eng_frame_own || loop);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_store    <= 1'b0;
            rx_store_id <= '0;
            cnt_q       <= 8'h0;
        end else begin
            rx_store <= store_d;
            if (store_d) begin
                rx_store_id <= eng_frame_id;
                cnt_q       <= cnt_q + 8'h1;
            end
        end
    end

    // checks
    a_listen_silent: assert property (@(posedge pclk) disable iff (!presetn)
        m_listen |=> can_tx) else $error("listen-only drove the bus");
    a_listen_rx_bus: assert property (@(posedge pclk) disable iff (!presetn)
        m_listen |=> eng_rx == $past(bus_rx_q)) else $error("listen-only rx not bus");
    a_tx_req_block: assert property (@(posedge pclk) disable iff (!presetn)
        m_listen |-> !eng_tx_req) else $error("tx request passed in listen-only");
    a_refused_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (m_listen && host_tx_req) |=> refused_q) else $error("refused flag not set");
    a_int_loop_rx: assert property (@(posedge pclk) disable iff (!presetn)
        (m_int && !eng_ack_slot) |=> eng_rx == $past(eng_tx)) else $error("int loop rx");
    a_int_self_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (m_int && eng_ack_slot) |=> !eng_rx) else $error("no self ack internal");
    a_own_store: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_frame_ok && eng_frame_own && loop && match) |=> rx_store && cnt_q == $past(cnt_q) + 8'h1)
        else $error("own frame not stored");
    a_own_no_store: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_frame_ok && eng_frame_own && !loop) |=> !rx_store) else $error("own frame stored");
    a_ext_drive: assert property (@(posedge pclk) disable iff (!presetn)
        m_ext |=> can_tx == $past(eng_tx)) else $error("ext loop not driving bus");
    a_ext_self_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (m_ext && eng_ack_slot) |=> !eng_rx) else $error("no self ack external");
    a_int_recessive: assert property (@(posedge pclk) disable iff (!presetn)
        m_int [*2] |-> can_tx) else $error("internal loop drove the pin");

    // frame acceptance and its answer one cycle later
    sequence s_accept;
        eng_frame_ok && match && (!eng_frame_own || loop);
    endsequence

    sequence s_stored;
        rx_store && (rx_store_id == $past(eng_frame_id));
    endsequence

    // receive synchroniser stages agree
    sequence s_rx_agree;
        rx_s2_q == rx_s3_q;
    endsequence

    a_store_id: assert property (@(posedge pclk) disable iff (!presetn)
        s_accept |=> s_stored)
        else $error("accepted frame not stored with its id");

    a_store_only: assert property (@(posedge pclk) disable iff (!presetn)
        !eng_frame_ok |=> !rx_store)
        else $error("store without a completed frame");

    a_basic_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (m_basic && basic_q[CFTM_B_HOLD]) |=> can_tx)
        else $error("basic hold let the pin go dominant");

    a_basic_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (m_basic && basic_q[CFTM_B_SACK] && eng_ack_slot) |=> !eng_rx)
        else $error("basic self ack missing");

    a_basic_plain: assert property (@(posedge pclk) disable iff (!presetn)
        (m_basic && !basic_q[CFTM_B_SACK]) |=> eng_rx == $past(bus_rx_q))
        else $error("basic rx not bus without self ack");

    a_normal_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == CFTM_M_NORMAL || mode_q == CFTM_M_RESTR)
        |=> (can_tx == $past(eng_tx)) && (eng_rx == $past(bus_rx_q)))
        else $error("normal mode routing wrong");

    a_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q <= CFTM_M_RESTR)
        else $error("mode holds an illegal code");

    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CFTM_OFF_MODE && pwdata[2:0] <= CFTM_M_RESTR)
        |=> mode_q == $past(pwdata[2:0]))
        else $error("mode write not taken");

    a_mode_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CFTM_OFF_MODE && pwdata[2:0] > CFTM_M_RESTR) |=> $stable(mode_q))
        else $error("illegal mode write taken");

    a_listen_no_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (m_listen && eng_ack_slot) |=> can_tx)
        else $error("listen-only drove an ack");

    a_ext_rx_bus: assert property (@(posedge pclk) disable iff (!presetn)
        (m_ext && !eng_ack_slot) |=> eng_rx == $past(bus_rx_q && eng_tx))
        else $error("ext loop rx not bus and own bit");

    a_refused_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_refused && !(host_tx_req && m_listen)) |=> !refused_q)
        else $error("refused flag not cleared");

    a_sync_take: assert property (@(posedge pclk) disable iff (!presetn)
        s_rx_agree |=> bus_rx_q == $past(rx_s3_q))
        else $error("bus level not taken after agreement");

    a_quiet_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (quiet_q == 4'hF) |-> can_tx)
        else $error("long listen-only spell drove the bus");
endmodule

/* testbench/cftm_peer.sv */
// far-side model: one more node on a wired-AND bus; the bus idles recessive
// assumes 1 = recessive on dut_tx and bus_lvl, peer_dom is 1 = dominant, and a pull-up on the bus
`timescale 1ns/1ns
module cftm_peer (
    // bus pins
    input  wire logic dut_tx,
    input  wire logic peer_dom,
    output logic      bus_lvl
);
    // any node driving dominant pulls the bus low
    assign bus_lvl = dut_tx & ~peer_dom;
endmodule

/* testbench/cftm_top_test.sv */
// self-checking bench for the test-mode block: apb host, engine stub, bus peer
// assumes pclk at 125 MHz and zero-wait apb answers
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module cftm_top_test;
    import cftm_pkg::*;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [CFTM_AW-1:0]  paddr;
    logic [31:0]         pwdata, prdata, d;
    logic                eng_tx, eng_ack_slot, eng_rx, host_tx_req, eng_tx_req;
    logic                eng_frame_ok, eng_frame_own, rx_store, can_rx, can_tx, peer_dom;
    logic [CFTM_IDW-1:0] eng_frame_id, rx_store_id, fid, msk;
    logic                e;
    logic [7:0]          n_st;
    logic [CFTM_IDW-1:0] last_id;
    logic [2:0]          mt [3] = '{CFTM_M_NORMAL, CFTM_M_EXTLB, CFTM_M_INTLB};
    int                  num_errors, checks_done;
    cftm_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eng_tx(eng_tx), .eng_ack_slot(eng_ack_slot),
        .eng_rx(eng_rx), .host_tx_req(host_tx_req), .eng_tx_req(eng_tx_req),
        .eng_frame_ok(eng_frame_ok), .eng_frame_own(eng_frame_own),
        .eng_frame_id(eng_frame_id), .rx_store(rx_store), .rx_store_id(rx_store_id),
        .can_rx(can_rx), .can_tx(can_tx));
    cftm_peer PEER (.dut_tx(can_tx), .peer_dom(peer_dom), .bus_lvl(can_rx));
    function automatic logic exp_st(logic [2:0] m, logic own, logic [CFTM_IDW-1:0] id);
        return (((id ^ fid) & msk) == '0) && (!own || m == CFTM_M_EXTLB || m == CFTM_M_INTLB);
    endfunction
    task automatic apb(logic w, logic [CFTM_AW-1:0] a, logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        d = prdata;
        e = pslverr;
        `CHK("pready", 1'b1, pready)
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic frame(logic own, logic [CFTM_IDW-1:0] id, logic [2:0] m);
        @(posedge pclk);
        eng_frame_ok <= 1'b1; eng_frame_own <= own; eng_frame_id <= id;
        @(posedge pclk);
        eng_frame_ok <= 1'b0;
        #1 `CHK("rx_store", exp_st(m, own, id), rx_store)
        if (exp_st(m, own, id)) begin
            `CHK("rx_store_id", id, rx_store_id)
            n_st++;
            last_id = id;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, host_tx_req, eng_ack_slot, eng_frame_ok} = '0;
        {eng_frame_own, peer_dom, presetn} = '0;
        eng_tx = 1'b1; paddr = '0; pwdata = '0; eng_frame_id = '0;
        n_st = '0; last_id = '0;
        void'($urandom(61));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        #1 `CHK("can_tx idle", 1'b1, can_tx)
        apb(1'b0, CFTM_OFF_STAT, '0); `CHK("mode rst", CFTM_MODE_RST, d[2:0])
        for (int m = 0; m < 7; m++) begin
            apb(1'b1, CFTM_OFF_MODE, m);
            apb(1'b0, CFTM_OFF_STAT, '0); `CHK("mode", (m > 5) ? 3'h5 : m[2:0], d[2:0])
        end
        apb(1'b0, 12'h0FC, '0); `CHK("unmapped err", 1'b1, e)
        apb(1'b1, CFTM_OFF_MODE, CFTM_M_LISTEN);
        host_tx_req <= 1'b1; eng_tx <= 1'b0; peer_dom <= 1'b1; eng_ack_slot <= 1'b1;
        tick(16); `CHK("listen tx req", 1'b0, eng_tx_req)
        `CHK("listen pin", 1'b1, can_tx)
        `CHK("listen rx", 1'b0, eng_rx)
        apb(1'b0, CFTM_OFF_STAT, '0); `CHK("refused", 1'b1, d[CFTM_S_REFUSED])
        host_tx_req <= 1'b0; peer_dom <= 1'b0; eng_ack_slot <= 1'b0;
        apb(1'b1, CFTM_OFF_STAT, 32'h00000008);
        apb(1'b0, CFTM_OFF_STAT, '0); `CHK("refused clr", 1'b0, d[CFTM_S_REFUSED])
        apb(1'b1, CFTM_OFF_MODE, CFTM_M_INTLB);
        host_tx_req <= 1'b1;
        tick(6); `CHK("int pin", 1'b1, can_tx)
        `CHK("int loop", 1'b0, eng_rx)
        `CHK("int tx req", 1'b1, eng_tx_req)
        host_tx_req <= 1'b0;
        eng_tx <= 1'b1; eng_ack_slot <= 1'b1;
        tick(3); `CHK("int ack", 1'b0, eng_rx)
        eng_ack_slot <= 1'b0; peer_dom <= 1'b1;
        tick(6); `CHK("int no bus", 1'b1, eng_rx)
        peer_dom <= 1'b0; eng_tx <= 1'b0;
        apb(1'b1, CFTM_OFF_MODE, CFTM_M_EXTLB);
        tick(6); `CHK("ext pin", 1'b0, can_tx)
        `CHK("ext rx", 1'b0, eng_rx)
        eng_tx <= 1'b1; eng_ack_slot <= 1'b1;
        tick(6); `CHK("ext ack", 1'b0, eng_rx)
        eng_ack_slot <= 1'b0;
        fid = $urandom; msk = '1;
        apb(1'b1, CFTM_OFF_FID, {3'h0, fid});
        apb(1'b1, CFTM_OFF_FMASK, {3'h0, msk});
        for (int i = 0; i < 18; i++) begin
            apb(1'b1, CFTM_OFF_MODE, mt[i % 3]);
            frame($urandom, ($urandom % 2) ? fid : fid ^ (29'h1 << ($urandom % 29)), mt[i % 3]);
        end
        apb(1'b0, CFTM_OFF_STAT, '0); `CHK("store count", n_st, d[15:8])
        apb(1'b0, CFTM_OFF_LID, '0); `CHK("last id", last_id, d[CFTM_IDW-1:0])
        apb(1'b1, CFTM_OFF_MODE, CFTM_M_BASIC);
        apb(1'b1, CFTM_OFF_BASIC, 32'h00000003);
        eng_tx <= 1'b0;
        tick(3); `CHK("basic hold", 1'b1, can_tx)
        eng_tx <= 1'b1; eng_ack_slot <= 1'b1;
        tick(6); `CHK("basic ack", 1'b0, eng_rx)
        wrap_up();
    end
endmodule
